//--- word_store.sv
// Shared word storage with processor-priority arbitration between processor and channel
`timescale 1ns/1ns
`default_nettype none
module word_store #(
    parameter int WIDTH = word_store_pkg::WORD_BITS,
    parameter int AW    = word_store_pkg::ADDR_BITS
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Processor port
    input  wire logic             cpu_req_in,
    input  wire logic             cpu_wr_in,
    input  wire logic [AW-1:0]    cpu_addr_in,
    input  wire logic [WIDTH-1:0] cpu_wdata_in,
    input  wire logic             cpu_release_in,
    output logic                  cpu_done_out,
    output logic      [WIDTH-1:0] cpu_rdata_out,
    // Channel port
    input  wire logic             chan_req_in,
    input  wire logic             chan_wr_in,
    input  wire logic [AW-1:0]    chan_addr_in,
    input  wire logic [WIDTH-1:0] chan_wdata_in,
    output logic                  chan_done_out,
    output logic      [WIDTH-1:0] chan_rdata_out,
    output logic                  chan_wait_out,
    // Status
    output logic                  busy_out,
    output logic                  rdata_neg_out
);
    // ============================================================
    // Elaboration checks
    initial begin
        if (WIDTH != word_store_pkg::WORD_BITS || AW != word_store_pkg::ADDR_BITS) begin
            $error("word_store: geometry must be 36 bits by 15 address bits");
        end
        if ((1 << AW) != word_store_pkg::WORD_COUNT) begin
            $error("word_store: address width does not cover the word count");
        end
        if (word_store_pkg::ACCESS_CLK >= word_store_pkg::STORE_CYCLE_CLK) begin
            $error("word_store: access exceeds storage cycle");
        end
    end

    // ============================================================
    // State
    word_store_pkg::arb_state_t state_reg, state_next;
    logic [1:0]       grant_reg, grant_next;
    logic             cpu_hold_reg;   // Processor keeps priority until it releases
    logic             wr_reg;
    logic [AW-1:0]    addr_reg;
    logic [WIDTH-1:0] wdata_reg;
    logic [WIDTH-1:0] array_rdata;

    // Processor wins unless it has released priority and channel asks
    wire cpu_pick  = cpu_req_in && !(chan_req_in && !cpu_hold_reg);
    wire chan_pick = chan_req_in && !cpu_pick;
    wire start     = (state_reg == word_store_pkg::ST_IDLE) && (cpu_pick || chan_pick);
    wire mem_we    = (state_reg == word_store_pkg::ST_BUSY) && wr_reg;

    // Next-state decode
    always_comb begin
        state_next = state_reg;
        grant_next = grant_reg;
        case (state_reg)
            word_store_pkg::ST_IDLE: begin
                if (start) begin
                    state_next = word_store_pkg::ST_BUSY;
                    grant_next = cpu_pick ? word_store_pkg::GRANT_CPU : word_store_pkg::GRANT_CHAN;
                end
            end
            word_store_pkg::ST_BUSY: state_next = word_store_pkg::ST_DONE;
            word_store_pkg::ST_DONE: begin
                state_next = word_store_pkg::ST_IDLE;
                grant_next = word_store_pkg::GRANT_NONE;
            end
            default: begin
                state_next = word_store_pkg::ST_IDLE;
                grant_next = word_store_pkg::GRANT_NONE;
            end
        endcase
    end

    // Latch request at start so address and direction hold for the access
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg    <= word_store_pkg::ST_IDLE;
            grant_reg    <= word_store_pkg::GRANT_NONE;
            cpu_hold_reg <= 1'b1;
            wr_reg       <= 1'b0;
            addr_reg     <= '0;
            wdata_reg    <= '0;
        end else begin
            state_reg <= state_next;
            grant_reg <= grant_next;
            if (cpu_release_in) begin
                cpu_hold_reg <= 1'b0;
            end else if (cpu_req_in && !chan_req_in) begin
                cpu_hold_reg <= 1'b1;
            end
            if (start) begin
                wr_reg    <= cpu_pick ? cpu_wr_in : chan_wr_in;
                addr_reg  <= cpu_pick ? cpu_addr_in : chan_addr_in;
                wdata_reg <= cpu_pick ? cpu_wdata_in : chan_wdata_in;
            end
        end
    end

    // Word array, addressed from zero
    word_store_array #(
        .WIDTH(WIDTH),
        .AW   (AW)
    ) u_array (
        .clk_in   (clk_in),
        .wr_en_in (mem_we),
        .addr_in  (addr_reg),
        .wdata_in (wdata_reg),
        .rdata_out(array_rdata)
    );

    // Answer registers: read word routed to the owner, 36 bits whole
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cpu_rdata_out  <= '0;
            chan_rdata_out <= '0;
            rdata_neg_out  <= 1'b0;
        end else if (state_reg == word_store_pkg::ST_DONE && !wr_reg) begin
            if (grant_reg == word_store_pkg::GRANT_CPU) begin
                cpu_rdata_out <= array_rdata;
            end else begin
                chan_rdata_out <= array_rdata;
            end
            rdata_neg_out <= array_rdata[word_store_pkg::SIGN_POS];
        end
    end

    // Handshake outputs are combinational
    assign cpu_done_out  = (state_reg == word_store_pkg::ST_DONE) && (grant_reg == word_store_pkg::GRANT_CPU);
    assign chan_done_out = (state_reg == word_store_pkg::ST_DONE) && (grant_reg == word_store_pkg::GRANT_CHAN);
    assign chan_wait_out = chan_req_in && !(start && chan_pick);
    assign busy_out      = (state_reg != word_store_pkg::ST_IDLE);

    // ============================================================
    // Checks
    sequence s_start_busy;
        start ##1 (state_reg == word_store_pkg::ST_BUSY);
    endsequence

    a_one_owner: assert property (@(posedge clk_in) disable iff (rst_in)
        !(cpu_done_out && chan_done_out))
        else $error("both requesters own storage");
    a_access_time: assert property (@(posedge clk_in) disable iff (rst_in)
        s_start_busy |-> ##1 (cpu_done_out || chan_done_out))
        else $error("access did not finish in time");
    a_cpu_priority: assert property (@(posedge clk_in) disable iff (rst_in)
        (start && cpu_req_in && cpu_hold_reg) |=> (grant_reg == word_store_pkg::GRANT_CPU))
        else $error("processor lost priority");
    a_step_order: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == word_store_pkg::ST_DONE) |=> (state_reg == word_store_pkg::ST_IDLE))
        else $error("new access before completion");
    a_write_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == word_store_pkg::ST_DONE) |-> $stable(wr_reg) && $stable(addr_reg) && $stable(wdata_reg))
        else $error("request changed during access");
    a_write_store: assert property (@(posedge clk_in) disable iff (rst_in)
        (mem_we) |=> ##1 (u_array.mem_reg[$past(addr_reg, 2)] == $past(wdata_reg, 2)))
        else $error("whole word not stored");
    a_read_keep: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == word_store_pkg::ST_BUSY && !wr_reg)
        |=> (u_array.mem_reg[$past(addr_reg)] == $past(u_array.mem_reg[addr_reg])))
        else $error("read changed contents");
    a_chan_answer: assert property (@(posedge clk_in) disable iff (rst_in)
        (chan_done_out && !wr_reg) |=> (chan_rdata_out == $past(array_rdata)))
        else $error("channel read word wrong");
    a_sign_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        ((cpu_done_out || chan_done_out) && !wr_reg)
        |=> (rdata_neg_out == $past(array_rdata[word_store_pkg::SIGN_POS])))
        else $error("sign flag wrong");
endmodule
`default_nettype wire

//--- word_store_pkg.sv
// Package of constants for the shared word storage and its arbiter
`default_nettype none
package word_store_pkg;
    // ============================================================
    // Word and address geometry
    localparam int WORD_BITS  = 36;
    localparam int ADDR_BITS  = 15;
    localparam int WORD_COUNT = 32768;
    localparam int SIGN_POS   = 35;
    localparam int MAG_BITS   = 35;
    // ============================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int STORE_CYCLE_PS  = 2180000;
    // Longest time rounds down
    localparam int STORE_CYCLE_CLK = STORE_CYCLE_PS / CLK_PERIOD_PS;
    localparam int ACCESS_CLK      = 2;
    // ============================================================
    // Arbiter states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } arb_state_t;
    localparam logic [1:0] GRANT_NONE = 2'b00;
    localparam logic [1:0] GRANT_CPU  = 2'b01;
    localparam logic [1:0] GRANT_CHAN = 2'b10;
endpackage
`default_nettype wire

//--- word_store_array.sv
// Word array of the shared storage: whole-word parallel read and write
`timescale 1ns/1ns
`default_nettype none
module word_store_array #(
    parameter int WIDTH = word_store_pkg::WORD_BITS,
    parameter int AW    = word_store_pkg::ADDR_BITS
) (
    input  wire logic             clk_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    addr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] rdata_out
);
    // ============================================================
    // Storage
    logic [WIDTH-1:0] mem_reg [0:(1<<AW)-1];

    // Whole word stored or fetched in one edge; fetch never writes back
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[addr_in] <= wdata_in;
        end
        rdata_out <= mem_reg[addr_in];
    end
endmodule
`default_nettype wire

//--- requester_model.sv
// Requester model that stands in for the processor or a data channel
`timescale 1ns/1ns
`default_nettype none
module requester_model (
    input  wire logic        clk_in,
    input  wire logic        done_in,
    input  wire logic [35:0] rdata_in,
    output logic             req_out,
    output logic             wr_out,
    output logic [14:0]      addr_out,
    output logic [35:0]      wdata_out
);
    // ==========================================
    // Idle until called
    initial begin
        req_out   = 1'b0;
        wr_out    = 1'b0;
        addr_out  = 15'h0000;
        wdata_out = 36'h0_0000_0000;
    end

    // One whole-word access, held until done, data taken only after done
    task automatic access(input logic w, input logic [14:0] a, input logic [35:0] d,
                          output logic [35:0] q, output int lat);
        @(negedge clk_in);
        req_out   = 1'b1;
        wr_out    = w;
        addr_out  = a;
        wdata_out = d;
        lat       = 0;
        do begin
            @(negedge clk_in);
            lat++;
        end while (done_in !== 1'b1 && lat < 400);
        @(negedge clk_in);
        q         = rdata_in;
        req_out   = 1'b0;
        // Released lines flip so a stale value cannot pass for a held one
        wr_out    = ~w;
        addr_out  = ~a;
        wdata_out = ~d;
    endtask
endmodule
`default_nettype wire

//--- word_store_tb_top.sv
// Self-checking testbench for the shared word storage
`timescale 1ns/1ns
`default_nettype none
module word_store_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rel = 1'b0;
    logic        c_req, c_wr, c_done, h_req, h_wr, h_done, h_wait, busy, neg;
    logic [14:0] c_addr, h_addr;
    logic [35:0] c_wd, c_rd, h_wd, h_rd, q, q2;
    int          mismatches = 0;
    int          n_checks   = 0;
    int          lat, lat2;

    // ==========================================
    // Clock, design and the two requesters
    initial forever #4 clk = ~clk;

    word_store dut (.clk_in(clk), .rst_in(rst), .cpu_req_in(c_req), .cpu_wr_in(c_wr),
        .cpu_addr_in(c_addr), .cpu_wdata_in(c_wd), .cpu_release_in(rel), .cpu_done_out(c_done),
        .cpu_rdata_out(c_rd), .chan_req_in(h_req), .chan_wr_in(h_wr), .chan_addr_in(h_addr),
        .chan_wdata_in(h_wd), .chan_done_out(h_done), .chan_rdata_out(h_rd),
        .chan_wait_out(h_wait), .busy_out(busy), .rdata_neg_out(neg));
    requester_model cpu_m (.clk_in(clk), .done_in(c_done), .rdata_in(c_rd), .req_out(c_req),
        .wr_out(c_wr), .addr_out(c_addr), .wdata_out(c_wd));
    requester_model ch_m (.clk_in(clk), .done_in(h_done), .rdata_in(h_rd), .req_out(h_req),
        .wr_out(h_wr), .addr_out(h_addr), .wdata_out(h_wd));

    // ==========================================
    // Comparison and verdict
    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // Idle outputs straight after reset: nobody owns storage
    task automatic t_reset_state();
        check("reset busy", 36'(busy), 36'h0_0000_0000);
        check("reset cpu done", 36'(c_done), 36'h0_0000_0000);
        check("reset chan done", 36'(h_done), 36'h0_0000_0000);
        check("reset chan wait", 36'(h_wait), 36'h0_0000_0000);
        check("reset cpu word", c_rd, 36'h0_0000_0000);
    endtask

    // Both ends of the address range written, the low end read twice, then the high end by the channel
    task automatic t_edges();
        cpu_m.access(1'b1, 15'h0000, 36'h8_0000_0001, q, lat);
        check("write latency", 36'(lat), 36'h0_0000_0002);
        cpu_m.access(1'b1, 15'h7FFF, 36'h7_FFFF_FFFE, q, lat);
        for (int i = 0; i < 2; i++) begin
            cpu_m.access(1'b0, 15'h0000, 36'h0_0000_0000, q, lat);
            check("read low", q, 36'h8_0000_0001);
            check("sign low", 36'(neg), 36'h0_0000_0001);
        end
        ch_m.access(1'b0, 15'h7FFF, 36'h0_0000_0000, q, lat);
        check("read high", q, 36'h7_FFFF_FFFE);
        check("sign high", 36'(neg), 36'h0_0000_0000);
    endtask

    // Both request at once; the winner depends on the priority pass
    task automatic t_contend(input logic r);
        rel = r;
        fork
            cpu_m.access(1'b0, 15'h7FFF, 36'h0_0000_0000, q, lat);
            ch_m.access(1'b0, 15'h0000, 36'h0_0000_0000, q2, lat2);
            begin
                // Look just after both requests settle, before the taking edge
                @(negedge clk);
                #1;
                check("chan wait", 36'(h_wait), 36'(!r));
                // Wait stays up while the channel requests and nothing starts
                @(negedge clk);
                check("chan wait busy", 36'(h_wait), 36'h0_0000_0001);
                check("busy", 36'(busy), 36'h0_0000_0001);
            end
        join
        rel = 1'b0;
        check("cpu latency", 36'(lat), r ? 36'h0_0000_0005 : 36'h0_0000_0002);
        check("chan latency", 36'(lat2), r ? 36'h0_0000_0002 : 36'h0_0000_0005);
        check("cpu data", q, 36'h7_FFFF_FFFE);
        check("chan data", q2, 36'h8_0000_0001);
    endtask

    // ==========================================
    // Main sequence; the release scenario is followed by a second run of the edge test
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset_state();
        t_edges();
        t_contend(1'b0);
        t_contend(1'b1);
        t_edges();
        final_report();
    end

    // Whole run is well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
